// file: hw/port_ctl_pkg.sv
`default_nettype none
package port_ctl_pkg;
  // group widths
  localparam int G0_W = 7;
  localparam int G1_W = 8;
  localparam int G2_W = 8;
  localparam int G3_W = 4;
  localparam int EDGE_W = 5;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_G0_OUT = 8'h00;
  localparam logic [7:0] OFS_G0_DIR = 8'h04;
  localparam logic [7:0] OFS_G0_PU = 8'h08;
  localparam logic [7:0] OFS_G0_MODE = 8'h0C;
  localparam logic [7:0] OFS_G1_OUT = 8'h10;
  localparam logic [7:0] OFS_G1_DIR = 8'h14;
  localparam logic [7:0] OFS_G1_PU = 8'h18;
  localparam logic [7:0] OFS_G1_MODE = 8'h1C;
  localparam logic [7:0] OFS_G2_MODE = 8'h20;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h24;
  localparam logic [7:0] OFS_G3_OUT = 8'h28;
  localparam logic [7:0] OFS_G3_DIR = 8'h2C;
  localparam logic [7:0] OFS_G3_PU = 8'h30;
  localparam logic [7:0] OFS_G3_MODE = 8'h34;
  localparam logic [7:0] OFS_EDGE_CFG = 8'h38;

  // pin level word field positions
  localparam int LVL_G0_LSB = 0;
  localparam int LVL_G1_LSB = 8;
  localparam int LVL_G2_LSB = 16;
  localparam int LVL_G3_LSB = 24;

  // special pin positions
  localparam int G0_TIMER_BIT = 0;
  localparam int G0_SELECT_BIT = 5;
  localparam int G1_EDGE_BIT = 6;

  // values after reset: all pins input, port mode, no pull-up
  localparam logic [6:0] G0_DIR_RST = 7'h7F;
  localparam logic [7:0] G1_DIR_RST = 8'hFF;
  localparam logic [3:0] G3_DIR_RST = 4'hF;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] PU_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [9:0] EDGE_CFG_RST = 10'h000;

  // edge selection per request input, two bits each
  typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_mode_t;

  // bus data phase
  typedef enum logic {PH_IDLE, PH_WRITE} bus_phase_t;
endpackage : port_ctl_pkg
`default_nettype wire

// file: hw/edge_request_detect.sv
`timescale 1ns/1ps
`default_nettype none
module edge_request_detect #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // sampled pins and setup
  input wire logic [W-1:0] sample,
  input wire logic [W-1:0] armed,
  input wire logic [2*W-1:0] edge_cfg,
  // one-cycle requests
  output logic [W-1:0] request
);
  import port_ctl_pkg::*;

  logic [W-1:0] prev;

  // previous level of each input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev <= '0;
    end else begin
      prev <= sample;
    end
  end

  // valid edge selection per input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      request <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        case (edge_mode_t'(edge_cfg[2*i +: 2]))
          EDGE_RISE: request[i] <= armed[i] & sample[i] & ~prev[i]; // RL10
          EDGE_FALL: request[i] <= armed[i] & ~sample[i] & prev[i]; // RL10
          EDGE_BOTH: request[i] <= armed[i] & (sample[i] ^ prev[i]); // RL10
          default: request[i] <= 1'b0;
        endcase
      end
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // rising edge with rise-only setup raises a request
  rise_req_a: assert property ( // RL10
    (armed[0] && edge_cfg[1:0] == 2'h1 && !prev[0] && sample[0]) |=> request[0])
    else $error("rising edge missed");
  // falling edge under rise-only setup stays quiet
  fall_quiet_a: assert property ( // RL10
    (edge_cfg[1:0] == 2'h1 && prev[0] && !sample[0]) |=> !request[0])
    else $error("falling edge wrongly taken");
endmodule : edge_request_detect
`default_nettype wire

// file: hw/port_group_ctl.sv
// Contract
// (RL1) seven-pin group, direction chosen per bit
// (RL2) seven-pin group has a software pull-up select
// (RL3) eight-pin group, each pin direction set by its own bit
// (RL4) eight-pin group has a software pull-up select
// (RL5) third eight-pin group is input only, no drive, no direction
// (RL6) four-pin group, direction chosen per bit
// (RL7) four-pin group has a software pull-up select
// (RL8) port or alternate function chosen separately for every pin
// (RL9) seven-pin group feeds timer, serial and select functions in control mode
// (RL10) edge requests detect rising, falling or both edges as set
// (RL11) input-only group pins become analog channels in control mode
// (RL12) in control mode the peripheral drives or samples the pin
`timescale 1ns/1ps
`default_nettype none
module port_group_ctl (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // group 0 pins and peripherals
  input wire logic [port_ctl_pkg::G0_W-1:0] g0_pin_in,
  output logic [port_ctl_pkg::G0_W-1:0] g0_pin_out,
  output logic [port_ctl_pkg::G0_W-1:0] g0_pin_oe,
  output logic [port_ctl_pkg::G0_W-1:0] g0_pullup_en,
  input wire logic [port_ctl_pkg::G0_W-1:0] g0_alt_out,
  input wire logic [port_ctl_pkg::G0_W-1:0] g0_alt_oe,
  output logic [port_ctl_pkg::G0_W-1:0] g0_alt_in,
  // group 1 pins and peripherals
  input wire logic [port_ctl_pkg::G1_W-1:0] g1_pin_in,
  output logic [port_ctl_pkg::G1_W-1:0] g1_pin_out,
  output logic [port_ctl_pkg::G1_W-1:0] g1_pin_oe,
  output logic [port_ctl_pkg::G1_W-1:0] g1_pullup_en,
  input wire logic [port_ctl_pkg::G1_W-1:0] g1_alt_out,
  input wire logic [port_ctl_pkg::G1_W-1:0] g1_alt_oe,
  output logic [port_ctl_pkg::G1_W-1:0] g1_alt_in,
  // group 2 input-only pins
  input wire logic [port_ctl_pkg::G2_W-1:0] g2_pin_in,
  output logic [port_ctl_pkg::G2_W-1:0] analog_channel_inputs,
  // group 3 pins and peripherals
  input wire logic [port_ctl_pkg::G3_W-1:0] g3_pin_in,
  output logic [port_ctl_pkg::G3_W-1:0] g3_pin_out,
  output logic [port_ctl_pkg::G3_W-1:0] g3_pin_oe,
  output logic [port_ctl_pkg::G3_W-1:0] g3_pullup_en,
  input wire logic [port_ctl_pkg::G3_W-1:0] g3_alt_out,
  input wire logic [port_ctl_pkg::G3_W-1:0] g3_alt_oe,
  output logic [port_ctl_pkg::G3_W-1:0] g3_alt_in,
  // dedicated function inputs
  output logic timer_count_capture_input,
  output logic serial_select_input,
  output logic [port_ctl_pkg::EDGE_W-1:0] edge_interrupt_inputs
);
  import port_ctl_pkg::*;

  // software state
  logic [G0_W-1:0] g0_out;
  logic [G0_W-1:0] group0_direction_bits;
  logic [G0_W-1:0] group0_pullup_select;
  logic [G0_W-1:0] g0_mode;
  logic [G1_W-1:0] g1_out;
  logic [G1_W-1:0] group1_direction_bits;
  logic [G1_W-1:0] group1_pullup_select;
  logic [G1_W-1:0] g1_mode;
  logic [G2_W-1:0] g2_mode;
  logic [G3_W-1:0] g3_out;
  logic [G3_W-1:0] group3_direction_bits;
  logic [G3_W-1:0] group3_pullup_select;
  logic [G3_W-1:0] g3_mode;
  logic [2*EDGE_W-1:0] edge_cfg;

  // bus phase state
  bus_phase_t phase;
  logic [ADDR_W-1:0] wr_addr;
  logic addr_take;
  logic [31:0] pin_level;
  logic [31:0] next_rdata;

  // offset match, used by the read decoder
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // pin drive enable: port mode uses direction (1 = input), control mode the peripheral
  function automatic logic [7:0] drive_oe(input logic [7:0] dir, input logic [7:0] mode,
                                          input logic [7:0] alt_oe);
    drive_oe = (~mode & ~dir) | (mode & alt_oe);
  endfunction : drive_oe

  // pin drive level: latch in port mode, peripheral in control mode
  function automatic logic [7:0] drive_out(input logic [7:0] latch, input logic [7:0] mode,
                                           input logic [7:0] alt_out);
    drive_out = (~mode & latch) | (mode & alt_out);
  endfunction : drive_out

  // pull-up acts only on port-mode inputs
  function automatic logic [7:0] pull_on(input logic [7:0] pu, input logic [7:0] dir,
                                         input logic [7:0] mode);
    pull_on = pu & dir & ~mode;
  endfunction : pull_on

  assign addr_take = hsel & hready & htrans[1];

  // level word seen by software; analog pins read zero
  always_comb begin
    pin_level = 32'h0000_0000;
    pin_level[LVL_G0_LSB +: G0_W] = g0_pin_in;
    pin_level[LVL_G1_LSB +: G1_W] = g1_pin_in;
    pin_level[LVL_G2_LSB +: G2_W] = g2_pin_in & ~g2_mode; // RL11
    pin_level[LVL_G3_LSB +: G3_W] = g3_pin_in;
  end

  // read mux, sampled in the address phase
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit(haddr[ADDR_W-1:0], OFS_G0_OUT)) next_rdata[G0_W-1:0] = g0_out;
    if (hit(haddr[ADDR_W-1:0], OFS_G0_DIR)) next_rdata[G0_W-1:0] = group0_direction_bits;
    if (hit(haddr[ADDR_W-1:0], OFS_G0_PU)) next_rdata[G0_W-1:0] = group0_pullup_select;
    if (hit(haddr[ADDR_W-1:0], OFS_G0_MODE)) next_rdata[G0_W-1:0] = g0_mode;
    if (hit(haddr[ADDR_W-1:0], OFS_G1_OUT)) next_rdata[G1_W-1:0] = g1_out;
    if (hit(haddr[ADDR_W-1:0], OFS_G1_DIR)) next_rdata[G1_W-1:0] = group1_direction_bits;
    if (hit(haddr[ADDR_W-1:0], OFS_G1_PU)) next_rdata[G1_W-1:0] = group1_pullup_select;
    if (hit(haddr[ADDR_W-1:0], OFS_G1_MODE)) next_rdata[G1_W-1:0] = g1_mode;
    if (hit(haddr[ADDR_W-1:0], OFS_G2_MODE)) next_rdata[G2_W-1:0] = g2_mode;
    if (hit(haddr[ADDR_W-1:0], OFS_PIN_LEVEL)) next_rdata = pin_level;
    if (hit(haddr[ADDR_W-1:0], OFS_G3_OUT)) next_rdata[G3_W-1:0] = g3_out;
    if (hit(haddr[ADDR_W-1:0], OFS_G3_DIR)) next_rdata[G3_W-1:0] = group3_direction_bits;
    if (hit(haddr[ADDR_W-1:0], OFS_G3_PU)) next_rdata[G3_W-1:0] = group3_pullup_select;
    if (hit(haddr[ADDR_W-1:0], OFS_G3_MODE)) next_rdata[G3_W-1:0] = g3_mode;
    if (hit(haddr[ADDR_W-1:0], OFS_EDGE_CFG)) next_rdata[2*EDGE_W-1:0] = edge_cfg;
  end

  // bus phase tracking, zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= PH_IDLE;
      wr_addr <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        phase <= (addr_take && hwrite) ? PH_WRITE : PH_IDLE;
        wr_addr <= haddr[ADDR_W-1:0];
        if (addr_take && !hwrite) begin
          hrdata <= next_rdata;
        end
      end
    end
  end

  // register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      g0_out <= OUT_RST[G0_W-1:0];
      group0_direction_bits <= G0_DIR_RST;
      group0_pullup_select <= PU_RST[G0_W-1:0];
      g0_mode <= MODE_RST[G0_W-1:0];
      g1_out <= OUT_RST;
      group1_direction_bits <= G1_DIR_RST;
      group1_pullup_select <= PU_RST;
      g1_mode <= MODE_RST;
      g2_mode <= MODE_RST;
      g3_out <= OUT_RST[G3_W-1:0];
      group3_direction_bits <= G3_DIR_RST;
      group3_pullup_select <= PU_RST[G3_W-1:0];
      g3_mode <= MODE_RST[G3_W-1:0];
      edge_cfg <= EDGE_CFG_RST;
    end else if (phase == PH_WRITE) begin
      case (wr_addr)
        OFS_G0_OUT: g0_out <= hwdata[G0_W-1:0];
        OFS_G0_DIR: group0_direction_bits <= hwdata[G0_W-1:0]; // RL1
        OFS_G0_PU: group0_pullup_select <= hwdata[G0_W-1:0]; // RL2
        OFS_G0_MODE: g0_mode <= hwdata[G0_W-1:0]; // RL8
        OFS_G1_OUT: g1_out <= hwdata[G1_W-1:0];
        OFS_G1_DIR: group1_direction_bits <= hwdata[G1_W-1:0]; // RL3
        OFS_G1_PU: group1_pullup_select <= hwdata[G1_W-1:0]; // RL4
        OFS_G1_MODE: g1_mode <= hwdata[G1_W-1:0]; // RL8
        OFS_G2_MODE: g2_mode <= hwdata[G2_W-1:0]; // RL8
        OFS_G3_OUT: g3_out <= hwdata[G3_W-1:0];
        OFS_G3_DIR: group3_direction_bits <= hwdata[G3_W-1:0]; // RL6
        OFS_G3_PU: group3_pullup_select <= hwdata[G3_W-1:0]; // RL7
        OFS_G3_MODE: g3_mode <= hwdata[G3_W-1:0]; // RL8
        OFS_EDGE_CFG: edge_cfg <= hwdata[2*EDGE_W-1:0]; // RL10
        default: ;
      endcase
    end
  end

  // group 0 pin drive and peripheral sampling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      g0_pin_out <= '0;
      g0_pin_oe <= '0;
      g0_pullup_en <= '0;
      g0_alt_in <= '0;
    end else begin
      g0_pin_out <= G0_W'(drive_out(8'(g0_out), 8'(g0_mode),
        8'(g0_alt_out))); // RL12
      g0_pin_oe <= G0_W'(drive_oe(8'(group0_direction_bits), 8'(g0_mode),
        8'(g0_alt_oe))); // RL1
      g0_pullup_en <= G0_W'(pull_on(8'(group0_pullup_select), 8'(group0_direction_bits),
        8'(g0_mode))); // RL2
      g0_alt_in <= g0_pin_in & g0_mode; // RL9
    end
  end

  // group 1 pin drive and peripheral sampling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      g1_pin_out <= '0;
      g1_pin_oe <= '0;
      g1_pullup_en <= '0;
      g1_alt_in <= '0;
    end else begin
      g1_pin_out <= drive_out(g1_out, g1_mode, g1_alt_out); // RL12
      g1_pin_oe <= drive_oe(group1_direction_bits, g1_mode, g1_alt_oe); // RL3
      g1_pullup_en <= pull_on(group1_pullup_select, group1_direction_bits, g1_mode); // RL4
      g1_alt_in <= g1_pin_in & g1_mode; // RL12
    end
  end

  // group 2 has no drive; control mode hands pins to the converter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_channel_inputs <= '0;
    end else begin
      analog_channel_inputs <= g2_mode; // RL11
    end
  end

  // group 3 pin drive and peripheral sampling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      g3_pin_out <= '0;
      g3_pin_oe <= '0;
      g3_pullup_en <= '0;
      g3_alt_in <= '0;
    end else begin
      g3_pin_out <= G3_W'(drive_out(8'(g3_out), 8'(g3_mode),
        8'(g3_alt_out))); // RL12
      g3_pin_oe <= G3_W'(drive_oe(8'(group3_direction_bits), 8'(g3_mode),
        8'(g3_alt_oe))); // RL6
      g3_pullup_en <= G3_W'(pull_on(8'(group3_pullup_select), 8'(group3_direction_bits),
        8'(g3_mode))); // RL7
      g3_alt_in <= g3_pin_in & g3_mode; // RL12
    end
  end

  // dedicated inputs of group 0 in control mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_count_capture_input <= 1'b0;
      serial_select_input <= 1'b0;
    end else begin
      timer_count_capture_input <= g0_pin_in[G0_TIMER_BIT] & g0_mode[G0_TIMER_BIT]; // RL9
      serial_select_input <= g0_pin_in[G0_SELECT_BIT] & g0_mode[G0_SELECT_BIT]; // RL9
    end
  end

  // edge requests: group 3 pins and one group 1 pin
  edge_request_detect #(
    .W(EDGE_W)
  ) u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample({g1_pin_in[G1_EDGE_BIT], g3_pin_in}),
    .armed({g1_mode[G1_EDGE_BIT], g3_mode}),
    .edge_cfg(edge_cfg),
    .request(edge_interrupt_inputs)
  );

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // write address phase to a given offset
  sequence wr_addr_s(logic [ADDR_W-1:0] ofs);
    addr_take && hwrite && haddr[ADDR_W-1:0] == ofs;
  endsequence
  // port-mode group: drive follows inverted direction
  sequence port_mode_s(logic all_port);
    all_port ##1 all_port;
  endsequence

  g0_dir_write_a: assert property ( // RL1
    wr_addr_s(OFS_G0_DIR) ##1 1'b1 |=> group0_direction_bits == $past(hwdata[G0_W-1:0]))
    else $error("group 0 direction not written");
  g0_pullup_gate_a: assert property ( // RL2
    1'b1 |=> (g0_pullup_en & ~$past(group0_pullup_select)) == '0)
    else $error("group 0 pull-up without select");
  g1_port_drive_a: assert property ( // RL3
    port_mode_s(g1_mode == '0) |=> g1_pin_oe == ~$past(group1_direction_bits))
    else $error("group 1 drive ignores direction");
  g1_pullup_gate_a: assert property ( // RL4
    1'b1 |=> (g1_pullup_en & ~$past(group1_direction_bits)) == '0)
    else $error("group 1 pull-up on output");
  g2_input_only_a: assert property ( // RL5
    g2_mode != '0 |-> (pin_level[LVL_G2_LSB +: G2_W] & g2_mode) == '0)
    else $error("analog pin read as digital");
  g2_analog_sel_a: assert property ( // RL11
    wr_addr_s(OFS_G2_MODE) ##1 1'b1 |=> ##1 analog_channel_inputs == $past(g2_mode))
    else $error("analog channel select lags");
  g3_dir_write_a: assert property ( // RL6
    wr_addr_s(OFS_G3_DIR) ##1 1'b1 |=> group3_direction_bits == $past(hwdata[G3_W-1:0]))
    else $error("group 3 direction not written");
  g3_pullup_write_a: assert property ( // RL7
    wr_addr_s(OFS_G3_PU) ##1 1'b1 |=> group3_pullup_select == $past(hwdata[G3_W-1:0]))
    else $error("group 3 pull-up select not written");
  g3_alt_drive_a: assert property ( // RL12
    g3_mode == '1 |=> g3_pin_oe == $past(g3_alt_oe) && g3_pin_out == $past(g3_alt_out))
    else $error("peripheral not driving group 3");
  g0_mode_write_a: assert property ( // RL8
    wr_addr_s(OFS_G0_MODE) ##1 1'b1 |=> g0_mode == $past(hwdata[G0_W-1:0]))
    else $error("group 0 mode not written");
  timer_route_a: assert property ( // RL9
    !g0_mode[G0_TIMER_BIT] |=> !timer_count_capture_input)
    else $error("timer input active in port mode");
  bus_ready_a: assert property (
    hreadyout && !hresp)
    else $error("slave stalled or erred");
endmodule : port_group_ctl
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import port_ctl_pkg::*;
  // bus side stimulus
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  wire logic hready;
  wire logic hreadyout;
  wire logic [31:0] hrdata;
  wire logic hresp;
  // pin side stimulus, shared by groups 0, 1 and 3; group 2 has its own
  logic [7:0] pin_v = 8'h00;
  logic [7:0] aout_v = 8'h00;
  logic [7:0] aoe_v = 8'h00;
  logic [7:0] g2_v = 8'h00;
  wire logic [6:0] g0_oe, g0_out, g0_pu, g0_ai;
  wire logic [7:0] g1_oe, g1_out, g1_pu, g1_ai, analog;
  wire logic [3:0] g3_oe, g3_out, g3_pu, g3_ai;
  wire logic tmr;
  wire logic sel;
  wire logic [4:0] edges;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int pulse_cnt [5];
  // per-group views, index 0 1 2 for groups 0 1 3
  wire logic [7:0] oe_v [3];
  wire logic [7:0] out_v [3];
  wire logic [7:0] pu_v [3];
  wire logic [7:0] ai_v [3];
  localparam logic [7:0] REG_OFS [14] = '{OFS_G0_OUT, OFS_G0_DIR, OFS_G0_PU, OFS_G0_MODE,
    OFS_G1_OUT, OFS_G1_DIR, OFS_G1_PU, OFS_G1_MODE, OFS_G2_MODE, OFS_G3_OUT, OFS_G3_DIR,
    OFS_G3_PU, OFS_G3_MODE, OFS_EDGE_CFG};
  localparam logic [9:0] REG_MASK [14] = '{10'h07F, 10'h07F, 10'h07F, 10'h07F, 10'h0FF,
    10'h0FF, 10'h0FF, 10'h0FF, 10'h0FF, 10'h00F, 10'h00F, 10'h00F, 10'h00F, 10'h3FF};
  localparam logic [9:0] REG_RST [14] = '{10'h000, 10'h07F, 10'h000, 10'h000, 10'h000,
    10'h0FF, 10'h000, 10'h000, 10'h000, 10'h000, 10'h00F, 10'h000, 10'h000, 10'h000};
  localparam logic [7:0] BASE [3] = '{OFS_G0_OUT, OFS_G1_OUT, OFS_G3_OUT};
  localparam logic [7:0] GMASK [3] = '{8'h7F, 8'hFF, 8'h0F};

  assign hready = hreadyout;
  assign oe_v[0] = {1'b0, g0_oe};
  assign oe_v[1] = g1_oe;
  assign oe_v[2] = {4'h0, g3_oe};
  assign out_v[0] = {1'b0, g0_out};
  assign out_v[1] = g1_out;
  assign out_v[2] = {4'h0, g3_out};
  assign pu_v[0] = {1'b0, g0_pu};
  assign pu_v[1] = g1_pu;
  assign pu_v[2] = {4'h0, g3_pu};
  assign ai_v[0] = {1'b0, g0_ai};
  assign ai_v[1] = g1_ai;
  assign ai_v[2] = {4'h0, g3_ai};

  port_group_ctl dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .g0_pin_in(pin_v[6:0]), .g0_pin_out(g0_out), .g0_pin_oe(g0_oe), .g0_pullup_en(g0_pu),
    .g0_alt_out(aout_v[6:0]), .g0_alt_oe(aoe_v[6:0]), .g0_alt_in(g0_ai),
    .g1_pin_in(pin_v), .g1_pin_out(g1_out), .g1_pin_oe(g1_oe), .g1_pullup_en(g1_pu),
    .g1_alt_out(aout_v), .g1_alt_oe(aoe_v), .g1_alt_in(g1_ai),
    .g2_pin_in(g2_v), .analog_channel_inputs(analog),
    .g3_pin_in(pin_v[3:0]), .g3_pin_out(g3_out), .g3_pin_oe(g3_oe), .g3_pullup_en(g3_pu),
    .g3_alt_out(aout_v[3:0]), .g3_alt_oe(aoe_v[3:0]), .g3_alt_in(g3_ai),
    .timer_count_capture_input(tmr), .serial_select_input(sel),
    .edge_interrupt_inputs(edges));

  // clock, 20 ns period
  always #10 hclk = ~hclk;

  // count request pulses, one per cycle high
  always @(posedge hclk) begin
    for (int j = 0; j < 5; j++) begin
      if (edges[j] === 1'b1) pulse_cnt[j]++;
    end
  end

  // cut a hang short
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      miscompares++;
    end
  endtask : check

  // one single transfer; waits for hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0, "response not okay");
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    check(rd, exp, what);
  endtask : rd_chk

  // let register and pin changes reach the outputs
  task automatic settle();
    repeat (5) @(posedge hclk);
  endtask : settle

  // main sequence
  initial begin
    logic [7:0] md;
    logic [7:0] m;
    int i;
    int g;
    int k;
    int c;
    repeat (16) @(posedge hclk);
    check(32'(|{g0_oe, g1_oe, g3_oe, g0_pu, g1_pu, g3_pu, analog, edges, tmr, sel}), 0,
          "outputs active in reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, then width masks of every register
    for (i = 0; i < 14; i++) rd_chk(REG_OFS[i], {22'h0, REG_RST[i]}, "reset value");
    for (i = 0; i < 14; i++) begin
      wr(REG_OFS[i], 32'hFFFFFFA5);
      rd_chk(REG_OFS[i], 32'hFFFFFFA5 & {22'h0, REG_MASK[i]}, "masked readback");
    end
    wr(8'h3C, 32'hFFFFFFFF);
    rd_chk(8'h3C, 32'h0, "unmapped read");
    wr(OFS_PIN_LEVEL, 32'hFFFFFFFF);
    rd_chk(OFS_PIN_LEVEL, 32'h0, "pin level written");
    // port mode, then mixed control mode, on every group
    pin_v <= 8'h99;
    aout_v <= 8'h3C;
    aoe_v <= 8'h0F;
    g2_v <= 8'hC6;
    for (k = 0; k < 2; k++) begin
      md = (k == 1) ? 8'h5A : 8'h00;
      for (g = 0; g < 3; g++) begin
        wr(BASE[g], 32'h55);
        wr(BASE[g] + 8'h04, 32'hC3);
        wr(BASE[g] + 8'h08, 32'hFF);
        wr(BASE[g] + 8'h0C, {24'h0, md});
      end
      wr(OFS_G2_MODE, {24'h0, md});
      settle();
      for (g = 0; g < 3; g++) begin
        m = GMASK[g];
        check(32'(oe_v[g]), 32'((~8'hC3 & ~md | aoe_v & md) & m), "oe");
        check(32'(out_v[g]), 32'((8'h55 & ~md | aout_v & md) & m), "out");
        check(32'(pu_v[g]), 32'(8'hC3 & ~md & m), "pull-up");
        check(32'(ai_v[g]), 32'(pin_v & md & m), "alt in");
      end
      check(32'(analog), 32'(md), "analog select");
      rd_chk(OFS_PIN_LEVEL, {4'h0, pin_v[3:0], g2_v & ~md, pin_v, 1'b0, pin_v[6:0]},
             "pin level");
      check(32'({tmr, sel}), 32'h0, "function inputs in port");
    end
    // timer and select inputs follow their pins in control mode
    wr(OFS_G0_MODE, 32'h21);
    settle();
    check(32'({tmr, sel}), 32'h2, "timer and select");
    pin_v <= 8'h20;
    settle();
    check(32'({tmr, sel}), 32'h1, "timer and select");
    // edge requests for every selection
    pin_v <= 8'h00;
    wr(OFS_G3_MODE, 32'hF);
    wr(OFS_G1_MODE, 32'h40);
    for (i = 0; i < 5; i++) begin
      c = (i == 4) ? 3 : i;
      if (i == 4) wr(OFS_G3_MODE, 32'h0);
      wr(OFS_EDGE_CFG, {22'h0, {5{2'(c)}}});
      settle();
      @(negedge hclk);
      pulse_cnt = '{default: 0};
      @(posedge hclk);
      pin_v <= 8'h4F;
      settle();
      for (k = 0; k < 5; k++) begin
        check(32'(pulse_cnt[k]), (i < 4 || k == 4) ? 32'(c % 2) : 32'h0, "rise");
      end
      pin_v <= 8'h00;
      settle();
      for (k = 0; k < 5; k++) begin
        check(32'(pulse_cnt[k]), (i < 4 || k == 4) ? 32'(c % 2 + c / 2) : 32'h0,
              "fall");
      end
    end
    end_sim();
  end
endmodule : tb
`default_nettype wire
